/* design/lspwm_bank.sv */
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module lspwm_bank #(
  parameter bit FIRST_MODULE = 1'b1
) (
  // clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_n_i,
  // register bus
  input  wire lspwm_pkg::lspwm_avl_req_s avl_req_i,
  output logic                        avl_waitrequest_o,
  output logic [31:0]                 avl_readdata_o,
  // pressure control parameters
  input  wire lspwm_pkg::lspwm_param_s inlet_metering_valve_ctrl_i,
  input  wire lspwm_pkg::lspwm_param_s pressure_bleed_valve_ctrl_i,
  // lowside outputs
  output logic [3:0]                  lowside_out_o
);

  typedef struct packed {
    logic [3:0]                              lowside_channel_on;
    logic                                    pair_a_lock;
    logic                                    pair_b_lock;
    lspwm_pkg::lspwm_src_e                   ch1_param_source;
    lspwm_pkg::lspwm_src_e                   ch3_param_source;
    lspwm_pkg::lspwm_param_s [3:0]           cfg;
    lspwm_pkg::lspwm_param_s [3:0]           act;
    logic [3:0][24:0]                        phase;
    logic [3:0][31:0]                        elapsed;
    logic [3:0]                              out;
    logic                                    ack;
    logic [31:0]                             rdata;
  } lspwm_state_s;

  lspwm_state_s st;
  lspwm_state_s next_st;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] cyc_len(input lspwm_pkg::lspwm_param_s p);
    return 32'(p.pwm_cycle_ms * lspwm_pkg::CYC_PER_MS);
  endfunction : cyc_len

  // on-time decision; the compare is strict so zero never turns on and a full
  // share always does, which clamps the on time to the cycle
  function automatic logic on_now(input lspwm_pkg::lspwm_param_s p, input logic [24:0] ph,
                                  input logic [31:0] el);
    logic [63:0] lhs;
    logic [63:0] rhs;
    lhs = 64'(el) * 64'd100;
    rhs = 64'(p.pwm_on_percent) * 64'(cyc_len(p));
    if (p.on_time_format_select == lspwm_pkg::ON_MS) begin
      return 64'(el) < 64'(p.pwm_on_ms) * 64'(lspwm_pkg::CYC_PER_MS);
    end else if (p.pwm_on_percent >= 7'h64) begin
      return 1'b1;
    end else if (p.repeat_format_select == lspwm_pkg::REP_RATE) begin
      return 32'(ph) < 32'(p.pwm_on_percent) * lspwm_pkg::CYC_PER_PCT;
    end else begin
      return lhs < rhs;
    end
  endfunction : on_now

  function automatic lspwm_pkg::lspwm_param_s pick(input lspwm_pkg::lspwm_src_e s,
                                                   input lspwm_pkg::lspwm_param_s host);
    if (!FIRST_MODULE) begin
      return host;
    end
    case (s)
      lspwm_pkg::SRC_INLET: return inlet_metering_valve_ctrl_i;
      lspwm_pkg::SRC_BLEED: return pressure_bleed_valve_ctrl_i;
      default:              return host;
    endcase
  endfunction : pick

  logic [3:0]               bnd;
  lspwm_pkg::lspwm_param_s  sel [4];
  logic                     hit_ctrl;
  logic [7:0]               ch_ofs;
  logic [1:0]               ch_idx;

  always_comb begin
    logic [25:0] sum;
    logic [31:0] w;
    logic        en_any_a;
    logic        en_any_b;
    sum      = '0;
    w        = '0;
    en_any_a = st.lowside_channel_on[0] | st.lowside_channel_on[1];
    en_any_b = st.lowside_channel_on[2] | st.lowside_channel_on[3];
    next_st  = st;
    bnd      = '0;
    ch_ofs   = avl_req_i.address - lspwm_pkg::OFS_CH_BASE;
    ch_idx   = ch_ofs[4:3];
    hit_ctrl = 1'b0;

    sel[0] = pick(st.ch1_param_source, st.cfg[0]);
    sel[1] = st.cfg[1];
    sel[2] = pick(st.ch3_param_source, st.cfg[2]);
    sel[3] = st.cfg[3];

    // waveform generators
    for (int i = 0; i < 4; i++) begin
      sum = 26'(st.phase[i]) + 26'(st.act[i].pwm_rate_hz);
      if (!st.lowside_channel_on[i]) begin
        bnd[i] = 1'b1;
      end else if (st.act[i].repeat_format_select == lspwm_pkg::REP_RATE) begin
        bnd[i] = sum >= 26'(lspwm_pkg::CLK_HZ);
      end else begin
        bnd[i] = st.elapsed[i] + 32'h00000001 >= cyc_len(st.act[i]);
      end
      next_st.out[i] = st.lowside_channel_on[i] & on_now(st.act[i], st.phase[i],
                                                         st.elapsed[i]);
      if (bnd[i]) begin
        // loading only at the boundary keeps pulses whole when software rewrites
        next_st.act[i]     = sel[i];
        next_st.elapsed[i] = '0;
        next_st.phase[i]   = (st.lowside_channel_on[i] &&
                              st.act[i].repeat_format_select == lspwm_pkg::REP_RATE) ?
                             25'(sum - 26'(lspwm_pkg::CLK_HZ)) : '0;
      end else begin
        next_st.phase[i] = 25'(sum);
        if (st.elapsed[i] != 32'hFFFFFFFF) begin
          next_st.elapsed[i] = st.elapsed[i] + 32'h00000001;
        end
      end
    end
    if (st.pair_a_lock) begin
      next_st.out[1] = next_st.out[0];
    end
    if (st.pair_b_lock) begin
      next_st.out[3] = next_st.out[2];
    end

    // register bus: one wait cycle, answer on the second
    next_st.ack = (avl_req_i.read | avl_req_i.write) & ~st.ack;
    if (avl_req_i.address == lspwm_pkg::OFS_CTRL) begin
      hit_ctrl = 1'b1;
      w = {22'h0, st.ch3_param_source, st.ch1_param_source, st.pair_b_lock,
           st.pair_a_lock, st.lowside_channel_on};
    end else if (avl_req_i.address == lspwm_pkg::OFS_STATUS) begin
      w = {26'h0, st.pair_b_lock, st.pair_a_lock, st.out};
    end else if (avl_req_i.address >= lspwm_pkg::OFS_CH_BASE && ch_ofs < 8'h20 &&
                 ch_ofs[1:0] == 2'h0) begin
      if (ch_ofs[2:0] == lspwm_pkg::OFS_FMT[2:0]) begin
        w = {6'h0, st.cfg[ch_idx].on_time_format_select,
             st.cfg[ch_idx].repeat_format_select, 1'b0, st.cfg[ch_idx].pwm_on_percent,
             st.cfg[ch_idx].pwm_rate_hz};
      end else begin
        w = {st.cfg[ch_idx].pwm_on_ms, st.cfg[ch_idx].pwm_cycle_ms};
      end
    end
    if (avl_req_i.read && !st.ack) begin
      next_st.rdata = w;
    end
    if (avl_req_i.write && !st.ack) begin
      w = merge(w, avl_req_i.writedata, avl_req_i.byteenable);
      if (hit_ctrl) begin
        next_st.lowside_channel_on = w[lspwm_pkg::CTRL_EN_LSB +: 4];
        if (!en_any_a) begin
          next_st.pair_a_lock = w[lspwm_pkg::CTRL_LOCK_A];
        end
        if (!en_any_b) begin
          next_st.pair_b_lock = w[lspwm_pkg::CTRL_LOCK_B];
        end
        if (w[lspwm_pkg::CTRL_SRC1 +: 2] != 2'h3) begin
          next_st.ch1_param_source = lspwm_pkg::lspwm_src_e'(w[lspwm_pkg::CTRL_SRC1 +: 2]);
        end
        if (w[lspwm_pkg::CTRL_SRC3 +: 2] != 2'h3) begin
          next_st.ch3_param_source = lspwm_pkg::lspwm_src_e'(w[lspwm_pkg::CTRL_SRC3 +: 2]);
        end
      end else if (avl_req_i.address >= lspwm_pkg::OFS_CH_BASE && ch_ofs < 8'h20 &&
                   ch_ofs[1:0] == 2'h0) begin
        if (ch_ofs[2:0] == lspwm_pkg::OFS_FMT[2:0]) begin
          next_st.cfg[ch_idx].pwm_rate_hz    = w[lspwm_pkg::FMT_RATE_LSB +: 16];
          next_st.cfg[ch_idx].pwm_on_percent = w[lspwm_pkg::FMT_PCT_LSB +: 7];
          next_st.cfg[ch_idx].repeat_format_select =
            lspwm_pkg::lspwm_repeat_e'(w[lspwm_pkg::FMT_REPEAT]);
          next_st.cfg[ch_idx].on_time_format_select =
            lspwm_pkg::lspwm_on_e'(w[lspwm_pkg::FMT_ON]);
        end else begin
          next_st.cfg[ch_idx].pwm_cycle_ms = w[lspwm_pkg::LEN_CYC_LSB +: 16];
          next_st.cfg[ch_idx].pwm_on_ms    = w[lspwm_pkg::LEN_ON_LSB +: 16];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st                  <= '0;
      st.ch1_param_source <= lspwm_pkg::SRC_HOST;
      st.ch3_param_source <= lspwm_pkg::SRC_HOST;
      st.cfg              <= {4{lspwm_pkg::RST_PARAM}};
      st.act              <= {4{lspwm_pkg::RST_PARAM}};
    end else begin
      st <= next_st;
    end
  end

  assign avl_waitrequest_o = (avl_req_i.read | avl_req_i.write) & ~st.ack;
  assign avl_readdata_o    = st.rdata;
  assign lowside_out_o     = st.out;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_ctrl_write;
    avl_req_i.write && !st.ack && avl_req_i.address == lspwm_pkg::OFS_CTRL &&
    avl_req_i.byteenable[0];
  endsequence

  sequence s_busy_a;
    st.lowside_channel_on[1:0] != 2'b00;
  endsequence

  AST_OFF_IS_LOW: assert property (!st.lowside_channel_on[0] && !st.pair_a_lock |=>
    !lowside_out_o[0]) else $error("disabled channel pulsed");
  AST_LOCK_A_FOLLOW: assert property (st.pair_a_lock |=>
    lowside_out_o[1] == lowside_out_o[0]) else $error("pair a outputs differ");
  AST_LOCK_B_FOLLOW: assert property (st.pair_b_lock |=>
    lowside_out_o[3] == lowside_out_o[2]) else $error("pair b outputs differ");
  AST_LOCK_A_HELD: assert property (s_busy_a and s_ctrl_write |=>
    $stable(st.pair_a_lock)) else $error("pair a lock changed while running");
  AST_LOCK_B_HELD: assert property (st.lowside_channel_on[3:2] != 2'b00 |=>
    $stable(st.pair_b_lock)) else $error("pair b lock changed while running");
  AST_SRC_LOAD: assert property (bnd[0] |=> st.act[0] == $past(sel[0]))
    else $error("parameters not loaded at boundary");
  AST_FULL_ON: assert property (st.lowside_channel_on[0] &&
    st.act[0].on_time_format_select == lspwm_pkg::ON_PERCENT &&
    st.act[0].pwm_on_percent >= 7'h64 |=> lowside_out_o[0])
    else $error("full duty not on");
  AST_ZERO_OFF: assert property (st.act[2].on_time_format_select == lspwm_pkg::ON_PERCENT &&
    st.act[2].pwm_on_percent == 7'h00 |=> !lowside_out_o[2])
    else $error("zero duty pulsed");
  AST_BUS_ANSWER: assert property ((avl_req_i.read || avl_req_i.write) && !st.ack |=>
    !avl_waitrequest_o) else $error("bus answer late");

endmodule : lspwm_bank

/* design/lspwm_pkg.sv */
// Behaviour
// - a lowside output pulses only while its channel is on, or while locked to a leader that is on; otherwise stays inactive
// - with pair a locked, channel two follows channel one and ignores its own settings
// - with pair b locked, channel four follows channel three and ignores its own settings
// - pair a lock changes only while channels one and two are both off
// - pair b lock changes only while channels three and four are both off
// - a locked pair drives both outputs with identical, phase-aligned waveforms
// - channel one takes parameters from host, inlet valve control or bleed valve control
// - channel three has the same three-way parameter source choice
// - per channel, repetition comes from the rate in hertz or the cycle in ms
// - per channel, on time comes from the percentage or the pulse width in ms
// - rate format repeats at the given hertz; starts at 100 Hz
// - percent format keeps the output on that share of each cycle; starts at 50
// - cycle format repeats every given number of milliseconds
// - pulse width format keeps the output on the given milliseconds each cycle
// - the second module offers host parameters only but keeps pair locking
package lspwm_pkg;

  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MS_NS         = 1_000_000;
  localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned CYC_PER_PCT   = CLK_HZ / 100;
  localparam int unsigned NCH           = 4;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_CH_BASE = 8'h10;
  localparam logic [7:0] CH_STRIDE   = 8'h08;
  localparam logic [7:0] OFS_FMT     = 8'h00;
  localparam logic [7:0] OFS_LEN     = 8'h04;

  // control register fields
  localparam int unsigned CTRL_EN_LSB = 0;
  localparam int unsigned CTRL_LOCK_A = 4;
  localparam int unsigned CTRL_LOCK_B = 5;
  localparam int unsigned CTRL_SRC1   = 6;
  localparam int unsigned CTRL_SRC3   = 8;
  // channel format register fields
  localparam int unsigned FMT_RATE_LSB = 0;
  localparam int unsigned FMT_PCT_LSB  = 16;
  localparam int unsigned FMT_REPEAT   = 24;
  localparam int unsigned FMT_ON       = 25;
  // channel length register fields
  localparam int unsigned LEN_CYC_LSB = 0;
  localparam int unsigned LEN_ON_LSB  = 16;

  // values after reset
  localparam logic [15:0] RST_RATE_HZ = 16'h0064;
  localparam logic [6:0]  RST_PERCENT = 7'h32;
  localparam logic [15:0] RST_CYC_MS  = 16'h000A;
  localparam logic [15:0] RST_ON_MS   = 16'h0005;

  typedef enum logic [1:0] {SRC_HOST, SRC_INLET, SRC_BLEED} lspwm_src_e;
  typedef enum logic {REP_RATE, REP_CYCLE} lspwm_repeat_e;
  typedef enum logic {ON_PERCENT, ON_MS} lspwm_on_e;

  typedef struct packed {
    logic [15:0]   pwm_rate_hz;
    logic [6:0]    pwm_on_percent;
    logic [15:0]   pwm_cycle_ms;
    logic [15:0]   pwm_on_ms;
    lspwm_repeat_e repeat_format_select;
    lspwm_on_e     on_time_format_select;
  } lspwm_param_s;

  localparam lspwm_param_s RST_PARAM = '{RST_RATE_HZ, RST_PERCENT, RST_CYC_MS,
                                         RST_ON_MS, REP_RATE, ON_PERCENT};

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } lspwm_avl_req_s;

endpackage : lspwm_pkg

/* tb/lspwm_host.sv */
`timescale 1ns/1ps
module lspwm_host (
  // clock and answers from the block
  input  wire logic                  clk_sys_i,
  input  wire logic                  avl_waitrequest_i,
  input  wire logic [31:0]           avl_readdata_i,
  // requests and pressure control parameters
  output lspwm_pkg::lspwm_avl_req_s  avl_req_o,
  output lspwm_pkg::lspwm_param_s    inlet_o,
  output lspwm_pkg::lspwm_param_s    bleed_o
);
  initial begin
    avl_req_o = '0;
    inlet_o   = lspwm_pkg::RST_PARAM;
    bleed_o   = lspwm_pkg::RST_PARAM;
  end

  // request held until the rising edge that sees waitrequest low; read data taken at that edge
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    logic done;
    @(posedge clk_sys_i);
    avl_req_o <= '{~wr, wr, a, d, 4'hF};
    do begin
      @(posedge clk_sys_i);
      done = ~avl_waitrequest_i;
      q    = avl_readdata_i;
    end while (!done);
    avl_req_o.read  <= 1'b0;
    avl_req_o.write <= 1'b0;
  endtask : access
endmodule : lspwm_host

/* tb/lspwm_bank_tb.sv */
`timescale 1ns/1ps
module lspwm_bank_tb;
  logic                      clk_sys_i = 1'b0;
  logic                      rst_n_i   = 1'b0;
  lspwm_pkg::lspwm_avl_req_s avl_req;
  lspwm_pkg::lspwm_param_s   inlet;
  lspwm_pkg::lspwm_param_s   bleed;
  logic                      wait_req;
  logic [31:0]               rdata;
  logic [31:0]               q;
  logic [3:0]                lowside_out;
  int mismatches = 0;
  int checked    = 0;
  int cycles     = 0;
  int seed       = 39;
  int bad        = 0;
  int ctrl_m, per, hi, h, t, r, p;
  int fmt_m[4];
  int len_m[4];

  always #25 clk_sys_i = ~clk_sys_i;

  lspwm_host host (.clk_sys_i(clk_sys_i), .avl_waitrequest_i(wait_req),
    .avl_readdata_i(rdata), .avl_req_o(avl_req), .inlet_o(inlet), .bleed_o(bleed));
  lspwm_bank #(.FIRST_MODULE(1'b1)) DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .avl_req_i(avl_req), .avl_waitrequest_o(wait_req), .avl_readdata_o(rdata),
    .inlet_metering_valve_ctrl_i(inlet), .pressure_bleed_valve_ctrl_i(bleed),
    .lowside_out_o(lowside_out));

  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run

  // runaway guard: the planned sequence needs well under this many cycles
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      mismatches++;
      $display("[FAIL] %0t run hangs", $time);
      complete_run();
    end
  end

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t reg %h exp %h", $time, got, exp);
    end
  endtask : cmp_reg

  task automatic cmp_cnt(input int got, input int exp);
    checked++;
    if (got != exp) begin
      mismatches++;
      $display("[FAIL] %0t count %0d exp %0d", $time, got, exp);
    end
  endtask : cmp_cnt

  // bus write plus mirror update
  task automatic wr(input logic [7:0] a, input int d);
    host.access(1'b1, a, d, q);
    if (a == 8'h00) begin
      p = ctrl_m;
      p[3:0] = d[3:0];
      if (ctrl_m[1:0] == 0) p[4] = d[4];
      if (ctrl_m[3:2] == 0) p[5] = d[5];
      if (d[7:6] != 3) p[7:6] = d[7:6];
      if (d[9:8] != 3) p[9:8] = d[9:8];
      ctrl_m = p;
    end else if (a[2]) len_m[(a - 16) / 8] = d;
    else fmt_m[(a - 16) / 8] = d;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host.access(1'b0, a, 32'h0, q);
    cmp_reg(q, e);
  endtask : rd

  // expected period and on time from the mirror and the pressure control inputs
  task automatic expect_wave(input int ch);
    lspwm_pkg::lspwm_param_s s;
    int src;
    src = (ch == 0) ? ctrl_m[7:6] : (ch == 2) ? ctrl_m[9:8] : 0;
    s = '{fmt_m[ch][15:0], fmt_m[ch][22:16], len_m[ch][15:0], len_m[ch][31:16],
          lspwm_pkg::lspwm_repeat_e'(fmt_m[ch][24]), lspwm_pkg::lspwm_on_e'(fmt_m[ch][25])};
    if (src == 1) s = inlet;
    else if (src == 2) s = bleed;
    per = s.repeat_format_select ? s.pwm_cycle_ms * lspwm_pkg::CYC_PER_MS
                                 : lspwm_pkg::CLK_HZ / s.pwm_rate_hz;
    hi = s.on_time_format_select ? s.pwm_on_ms * lspwm_pkg::CYC_PER_MS
                                 : s.pwm_on_percent * per / 100;
    if (hi > per) hi = per;
  endtask : expect_wave

  task automatic step(input int ch, input int fol, inout int n);
    if (lowside_out[fol] !== lowside_out[ch]) bad++;
    n++;
    @(negedge clk_sys_i);
  endtask : step

  // first pulse after enable: high time in h, rise to rise in t
  task automatic measure(input int ch, input int fol);
    h = 0;
    t = 0;
    while (lowside_out[ch] !== 1'b1 && t < 50000) step(ch, fol, t);
    while (lowside_out[ch] === 1'b1 && h < 50000) step(ch, fol, h);
    t = h;
    while (lowside_out[ch] !== 1'b1 && t < 50000) step(ch, fol, t);
  endtask : measure

  task automatic count_high(input int ch);
    h = 0;
    repeat (1000) begin
      @(negedge clk_sys_i);
      if (lowside_out[ch] === 1'b1) h++;
      else if (lowside_out[ch] !== 1'b0) bad++;
    end
  endtask : count_high

  task automatic run_on(input int ctl, input int ch, input int fol);
    fork
      wr(8'h00, ctl);
      measure(ch, fol);
    join
    expect_wave(ch);
  endtask : run_on

  initial begin
    ctrl_m = 0;
    for (int i = 0; i < 4; i++) begin
      fmt_m[i] = 32'h0032_0064;
      len_m[i] = 32'h0005_000A;
    end
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(8'(16 + 8 * i), fmt_m[i]);
      rd(8'(20 + 8 * i), len_m[i]);
    end
    rd(8'h00, 32'h0);
    rd(8'h40, 32'h0);
    $display("reset test done");
    repeat (3) begin
      r = $random(seed);
      p = 10000 << (r[1:0] % 3);
      wr(8'h10, ((1 + r[12:4] % 99) << 16) | p);
      run_on(1, 0, 0);
      cmp_cnt(h, hi);
      cmp_cnt(t, per);
      wr(8'h00, 0);
    end
    $display("rate test done");
    wr(8'h18, 32'h0332_0064);
    wr(8'h1C, 32'h0001_0002);
    run_on(2, 1, 1);
    cmp_cnt(h, hi);
    cmp_cnt(t, per);
    wr(8'h00, 0);
    $display("ms test done");
    wr(8'h00, 32'h0000_0010);
    run_on(32'h0000_0011, 0, 1);
    cmp_cnt(t, per);
    cmp_cnt(bad, 0);
    wr(8'h00, 1);
    rd(8'h00, ctrl_m);
    wr(8'h00, 32'h0000_0010);
    wr(8'h00, 0);
    rd(8'h00, ctrl_m);
    $display("pair a test done");
    host.inlet_o <= '{16'h9C40, 7'h14, 16'h0001, 16'h0001,
                      lspwm_pkg::REP_RATE, lspwm_pkg::ON_PERCENT};
    wr(8'h00, 32'h0000_0120);
    run_on(32'h0000_0124, 2, 3);
    cmp_cnt(h, hi);
    cmp_cnt(t, per);
    cmp_cnt(bad, 0);
    wr(8'h00, 32'h0000_0304);
    rd(8'h00, ctrl_m);
    wr(8'h00, 0);
    wr(8'h00, 0);
    rd(8'h00, ctrl_m);
    $display("pair b test done");
    host.bleed_o <= '{16'h2710, 7'h3C, 16'h0001, 16'h0001,
                      lspwm_pkg::REP_RATE, lspwm_pkg::ON_PERCENT};
    wr(8'h00, 32'h0000_0080);
    run_on(32'h0000_0081, 0, 0);
    cmp_cnt(h, hi);
    cmp_cnt(t, per);
    wr(8'h00, 0);
    $display("source test done");
    wr(8'h28, 32'h0064_4E20);
    wr(8'h00, 8);
    count_high(3);
    cmp_cnt(h, 1000);
    rd(8'h04, 32'h0000_0008);
    wr(8'h00, 0);
    count_high(3);
    cmp_cnt(h, 0);
    wr(8'h28, 32'h0000_4E20);
    wr(8'h00, 8);
    count_high(3);
    cmp_cnt(h, 0);
    cmp_cnt(bad, 0);
    $display("clamp test done");
    complete_run();
  end
endmodule : lspwm_bank_tb
